// >>> cise_cfg.svh
// Offsets, field positions, reset values and cycle counts of the execution block.
// Assumes inclusion by the top module cise_exec only.
`ifndef CISE_CFG_SVH
`define CISE_CFG_SVH

// Register byte offsets
`define CISE_OFS_CTRL      8'h00
`define CISE_OFS_OPA       8'h04
`define CISE_OFS_OPB       8'h08
`define CISE_OFS_OFFSET    8'h0c
`define CISE_OFS_PC        8'h10
`define CISE_OFS_ZPTR      8'h14
`define CISE_OFS_STATUS_FLAGS_REGISTER      8'h18
`define CISE_OFS_IOREG     8'h1c
`define CISE_OFS_RESULT    8'h20
`define CISE_OFS_RETADDR   8'h24
`define CISE_OFS_INFO      8'h28

// Control word fields
`define CISE_CTRL_OP_LSB   0
`define CISE_CTRL_OP_MSB   5
`define CISE_CTRL_BIT_LSB  8
`define CISE_CTRL_BIT_MSB  10
`define CISE_CTRL_TWO_WORD 12
`define CISE_CTRL_START    16

// Status flag positions
`define CISE_FLAG_C        0
`define CISE_FLAG_Z        1
`define CISE_FLAG_N        2
`define CISE_FLAG_V        3
`define CISE_FLAG_S        4
`define CISE_FLAG_H        5
`define CISE_FLAG_T        6
`define CISE_FLAG_I        7

// Reset values and the all-ones mask
`define CISE_RST_BYTE      8'h00
`define CISE_RST_WORD      16'h0000
`define CISE_ALL_ONES      8'hff

// Cycle counts
`define CISE_CYC_ONE       2'd1
`define CISE_CYC_TWO       2'd2
`define CISE_CYC_THREE     2'd3

`endif

// >>> cise_pkg.sv
// Types shared by the execution block: operation codes and bus state.
// Assumes nothing beyond the constants header.
package cise_pkg;

   // Operation codes written into the control register
   typedef enum logic [5:0] {
      set_bits_with_mask         = 6'h00,
      clear_bits_with_mask       = 6'h01,
      test_register              = 6'h02,
      relative_jump              = 6'h03,
      indirect_jump_via_pointer  = 6'h04,
      relative_subroutine_call   = 6'h05,
      indirect_call_via_pointer  = 6'h06,
      compare_skip_equal         = 6'h07,
      compare_reg                = 6'h08,
      compare_with_carry         = 6'h09,
      compare_with_immediate     = 6'h0a,
      skip_reg_bit_clear         = 6'h0b,
      skip_reg_bit_set           = 6'h0c,
      skip_io_bit_clear          = 6'h0d,
      skip_io_bit_set            = 6'h0e,
      branch_status_bit_set      = 6'h0f,
      branch_status_bit_clear    = 6'h10,
      branch_signed_ge           = 6'h11,
      branch_signed_lt           = 6'h12,
      branch_half_carry_set      = 6'h13,
      branch_half_carry_clear    = 6'h14,
      branch_transfer_flag_set   = 6'h15,
      branch_transfer_flag_clear = 6'h16,
      branch_overflow_set        = 6'h17,
      branch_overflow_clear      = 6'h18,
      branch_irq_enabled         = 6'h19,
      branch_irq_disabled        = 6'h1a,
      branch_unsigned_ge         = 6'h1b,
      branch_unsigned_lt         = 6'h1c,
      branch_carry_set           = 6'h1d,
      branch_carry_clear         = 6'h1e,
      set_io_bit                 = 6'h1f,
      clear_io_bit               = 6'h20,
      shift_left_logical         = 6'h21,
      shift_right_logical        = 6'h22,
      bitwise_invert             = 6'h23,
      arith_sign_invert          = 6'h24,
      add_one_step               = 6'h25,
      subtract_one_step          = 6'h26,
      zero_fill_register         = 6'h27,
      ones_fill_register         = 6'h28
   } cise_op_type;

   // Bus answer state
   typedef enum logic [0:0] {
      cise_bus_idle   = 1'b0,
      cise_bus_answer = 1'b1
   } cise_bus_type;

endpackage : cise_pkg

// >>> cise_exec.sv
// Execution unit for a subset of an 8-bit core's instructions, reached over Avalon-MM.
// Assumes one 20 MHz clock, synchronous active-high reset and a master that holds
// each request until it sees waitrequest low.
//
// How it works
// - OR mask into register, Z N V
// - AND with inverted mask, Z N V
// - AND register with itself, Z N V
// - Jumps: relative or via Z, 2 cycles
// - Calls: relative or via Z, 3 cycles
// - Skip next if registers equal, 1/2/3
// - Compares subtract without writing, five flags
// - Skip on register bit clear or set
// - Skip on I/O bit clear or set
// - Branch on chosen status bit, 1/2 cycles
// - Signed branches use N xor V
// - Half-carry and T branches, both forms
// - Overflow branches, set or clear
// - Interrupt-enable branches, set or clear
// - Carry branches for unsigned comparisons
// - Set or clear one I/O bit, 2 cycles
// - Shift left, zero into bit 0
// - Shift right, zero into bit 7
`include "cise_cfg.svh"

module cise_exec
(
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        srst,
   // Avalon-MM slave
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // Completion of an operation
   output logic             exec_done
);
   import cise_pkg::*;

   // Architectural and operand state
   logic [7:0]   opa;
   logic [7:0]   opb;
   logic [11:0]  offset;
   logic [15:0]  pc;
   logic [15:0]  zptr;
   logic [7:0]   status_flags_register;
   logic [7:0]   ioreg;
   logic [7:0]   result;
   logic [15:0]  retaddr;
   cise_op_type  op;
   logic [2:0]   bitsel;
   logic         two_word;
   logic         busy;
   logic [1:0]   cyc_left;
   logic [1:0]   cyc_last;
   cise_bus_type bus_state;

   // Computed results
   logic [7:0]   next_result;
   logic [7:0]   next_status_flags_register;
   logic [7:0]   next_io;
   logic [15:0]  next_pc;
   logic [15:0]  next_ret;
   logic [1:0]   next_cycles;

   logic         bus_take;
   logic         wr_take;
   logic         start_take;
   logic         commit;

   // Relative target: pc plus signed offset plus one
   function automatic logic [15:0] rel_target(input logic [15:0] base,
                                              input logic [11:0] k);
      rel_target = base + {{4{k[11]}}, k} + 16'h0001;
   endfunction : rel_target

   // Subtraction with flag update; result in low byte, flags C Z N V H above
   function automatic logic [12:0] sub_flags(input logic [7:0] a,
                                             input logic [7:0] b,
                                             input logic       cin,
                                             input logic       zkeep);
      logic [7:0] r;
      logic       c;
      logic       h;
      logic       v;
      logic       z;
      r = a - b - {7'h00, cin};
      h = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
      v = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
      c = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
      z = (r == 8'h00) & zkeep;
      sub_flags = {h, v, r[7], z, c, r};
   endfunction : sub_flags

   // Skip step: two words for a one-word successor, three for a two-word one
   function automatic logic [15:0] skip_target(input logic [15:0] base,
                                               input logic        two);
      skip_target = base + (two ? 16'h0003 : 16'h0002);
   endfunction : skip_target

   // Bus request handshake and write strobes
   assign bus_take   = (avs_read | avs_write) & (bus_state == cise_bus_idle);
   assign wr_take    = avs_write & (bus_state == cise_bus_answer);
   assign start_take = wr_take & (avs_address == `CISE_OFS_CTRL)
                       & avs_writedata[`CISE_CTRL_START] & ~busy;

   // Last execution cycle; operands are frozen while busy, so the datapath holds still
   assign commit = busy & (((cyc_left == 2'd0) & (next_cycles == `CISE_CYC_ONE))
                   | (cyc_left == 2'd1));

   // Operation datapath
   always_comb
   begin
      logic [12:0] cmp;
      logic        cond;
      logic        is_branch;
      logic        is_skip;
      cmp         = 13'h0000;
      cond        = 1'b0;
      is_branch   = op inside {[branch_status_bit_set:branch_carry_clear]};
      is_skip     = op inside {compare_skip_equal, [skip_reg_bit_clear:skip_io_bit_set]};
      next_result = opa;
      next_status_flags_register   = status_flags_register;
      next_io     = ioreg;
      next_pc     = pc + 16'h0001;
      next_ret    = retaddr;
      next_cycles = `CISE_CYC_ONE;
      case (op)
         set_bits_with_mask:      next_result = opa | opb;
         clear_bits_with_mask:    next_result = opa & (`CISE_ALL_ONES - opb);
         test_register:           next_result = opa & opa;
         relative_jump, relative_subroutine_call:
            next_pc = rel_target(pc, offset);
         indirect_jump_via_pointer, indirect_call_via_pointer:
            next_pc = zptr;
         compare_skip_equal:      cond = (opa == opb);
         compare_reg, compare_with_immediate:
            cmp = sub_flags(opa, opb, 1'b0, 1'b1);
         compare_with_carry:
            cmp = sub_flags(opa, opb, status_flags_register[`CISE_FLAG_C], status_flags_register[`CISE_FLAG_Z]);
         skip_reg_bit_clear:      cond = ~opa[bitsel];
         skip_reg_bit_set:        cond = opa[bitsel];
         skip_io_bit_clear:       cond = ~ioreg[bitsel];
         skip_io_bit_set:         cond = ioreg[bitsel];
         branch_status_bit_set:   cond = status_flags_register[bitsel];
         branch_status_bit_clear: cond = ~status_flags_register[bitsel];
         branch_signed_ge:
            cond = ((status_flags_register[`CISE_FLAG_N] ^ status_flags_register[`CISE_FLAG_V]) == 1'b0);
         branch_signed_lt:
            cond = ((status_flags_register[`CISE_FLAG_N] ^ status_flags_register[`CISE_FLAG_V]) == 1'b1);
         branch_half_carry_set, branch_half_carry_clear:
            cond = status_flags_register[`CISE_FLAG_H] ^ (op == branch_half_carry_clear);
         branch_transfer_flag_set, branch_transfer_flag_clear:
            cond = status_flags_register[`CISE_FLAG_T] ^ (op == branch_transfer_flag_clear);
         branch_overflow_set, branch_overflow_clear:
            cond = status_flags_register[`CISE_FLAG_V] ^ (op == branch_overflow_clear);
         branch_irq_enabled, branch_irq_disabled:
            cond = status_flags_register[`CISE_FLAG_I] ^ (op == branch_irq_disabled);
         branch_unsigned_ge, branch_carry_clear:
            cond = ~status_flags_register[`CISE_FLAG_C];
         branch_unsigned_lt, branch_carry_set:
            cond = status_flags_register[`CISE_FLAG_C];
         set_io_bit:              next_io[bitsel] = 1'b1;
         clear_io_bit:            next_io[bitsel] = 1'b0;
         shift_left_logical:      next_result = {opa[6:0], 1'b0};
         shift_right_logical:     next_result = {1'b0, opa[7:1]};
         bitwise_invert:          next_result = `CISE_ALL_ONES - opa;
         arith_sign_invert:       next_result = 8'h00 - opa;
         add_one_step:            next_result = opa + 8'h01;
         subtract_one_step:       next_result = opa - 8'h01;
         zero_fill_register:      next_result = opa ^ opa;
         ones_fill_register:      next_result = `CISE_ALL_ONES;
         default:                 next_result = opa;
      endcase

      // Cycle counts, return address, taken branch and skip targets
      if (op inside {relative_jump, indirect_jump_via_pointer, set_io_bit, clear_io_bit})
         next_cycles = `CISE_CYC_TWO;
      if (op inside {relative_subroutine_call, indirect_call_via_pointer})
      begin
         next_ret    = pc + 16'h0001;
         next_cycles = `CISE_CYC_THREE;
      end
      if (is_branch & cond)
      begin
         next_pc     = rel_target(pc, offset);
         next_cycles = `CISE_CYC_TWO;
      end
      if (is_skip & cond)
      begin
         next_pc     = skip_target(pc, two_word);
         next_cycles = two_word ? `CISE_CYC_THREE : `CISE_CYC_TWO;
      end

      // Status flag update
      case (op)
         set_bits_with_mask, clear_bits_with_mask, test_register, zero_fill_register:
         begin
            next_status_flags_register[`CISE_FLAG_Z] = (next_result == 8'h00);
            next_status_flags_register[`CISE_FLAG_N] = next_result[7];
            next_status_flags_register[`CISE_FLAG_V] = 1'b0;
         end
         add_one_step, subtract_one_step:
         begin
            next_status_flags_register[`CISE_FLAG_Z] = (next_result == 8'h00);
            next_status_flags_register[`CISE_FLAG_N] = next_result[7];
            next_status_flags_register[`CISE_FLAG_V] = (op == add_one_step) ? (next_result == 8'h80)
                                                           : (next_result == 8'h7f);
         end
         compare_reg, compare_with_carry, compare_with_immediate:
         begin
            next_status_flags_register[`CISE_FLAG_C] = cmp[8];
            next_status_flags_register[`CISE_FLAG_Z] = cmp[9];
            next_status_flags_register[`CISE_FLAG_N] = cmp[10];
            next_status_flags_register[`CISE_FLAG_V] = cmp[11];
            next_status_flags_register[`CISE_FLAG_H] = cmp[12];
         end
         shift_left_logical, shift_right_logical:
         begin
            next_status_flags_register[`CISE_FLAG_Z] = (next_result == 8'h00);
            next_status_flags_register[`CISE_FLAG_C] = (op == shift_left_logical) ? opa[7] : opa[0];
            next_status_flags_register[`CISE_FLAG_N] = next_result[7];
            next_status_flags_register[`CISE_FLAG_V] = next_result[7] ^ next_status_flags_register[`CISE_FLAG_C];
         end
         bitwise_invert:
         begin
            next_status_flags_register[`CISE_FLAG_Z] = (next_result == 8'h00);
            next_status_flags_register[`CISE_FLAG_C] = 1'b1;
            next_status_flags_register[`CISE_FLAG_N] = next_result[7];
            next_status_flags_register[`CISE_FLAG_V] = 1'b0;
         end
         arith_sign_invert:
         begin
            next_status_flags_register[`CISE_FLAG_Z] = (next_result == 8'h00);
            next_status_flags_register[`CISE_FLAG_C] = (next_result != 8'h00);
            next_status_flags_register[`CISE_FLAG_N] = next_result[7];
            next_status_flags_register[`CISE_FLAG_V] = (next_result == 8'h80);
            next_status_flags_register[`CISE_FLAG_H] = next_result[3] | opa[3];
         end
         default: next_status_flags_register = status_flags_register;
      endcase
   end

   // Bus answer state: one wait cycle, then one answer cycle
   always_ff @(posedge sys_clk)
   begin
      if (srst)
         bus_state <= cise_bus_idle;
      else if (bus_take)
         bus_state <= cise_bus_answer;
      else
         bus_state <= cise_bus_idle;
   end

   // Waitrequest low only in the answer cycle
   always_ff @(posedge sys_clk)
   begin
      if (srst)
         avs_waitrequest <= 1'b1;
      else
         avs_waitrequest <= ~bus_take;
   end

   // Read data captured as the answer cycle begins
   always_ff @(posedge sys_clk)
   begin
      if (srst)
         avs_readdata <= 32'h0000_0000;
      else if (bus_take & avs_read)
      begin
         case (avs_address)
            `CISE_OFS_CTRL:    avs_readdata <= {15'h0000, busy, 3'h0, two_word,
                                                1'b0, bitsel, 2'h0, op};
            `CISE_OFS_OPA:     avs_readdata <= {24'h000000, opa};
            `CISE_OFS_OPB:     avs_readdata <= {24'h000000, opb};
            `CISE_OFS_OFFSET:  avs_readdata <= {20'h00000, offset};
            `CISE_OFS_PC:      avs_readdata <= {16'h0000, pc};
            `CISE_OFS_ZPTR:    avs_readdata <= {16'h0000, zptr};
            `CISE_OFS_STATUS_FLAGS_REGISTER:    avs_readdata <= {24'h000000, status_flags_register};
            `CISE_OFS_IOREG:   avs_readdata <= {24'h000000, ioreg};
            `CISE_OFS_RESULT:  avs_readdata <= {24'h000000, result};
            `CISE_OFS_RETADDR: avs_readdata <= {16'h0000, retaddr};
            `CISE_OFS_INFO:    avs_readdata <= {28'h0000000, cyc_last, cyc_left};
            default:           avs_readdata <= 32'h0000_0000;
         endcase
      end
   end

   // Operand registers, writable only while idle
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         opa      <= `CISE_RST_BYTE;
         opb      <= `CISE_RST_BYTE;
         offset   <= 12'h000;
         zptr     <= `CISE_RST_WORD;
         op       <= set_bits_with_mask;
         bitsel   <= 3'h0;
         two_word <= 1'b0;
      end
      else if (wr_take & ~busy)
      begin
         case (avs_address)
            `CISE_OFS_OPA:    opa    <= avs_writedata[7:0];
            `CISE_OFS_OPB:    opb    <= avs_writedata[7:0];
            `CISE_OFS_OFFSET: offset <= avs_writedata[11:0];
            `CISE_OFS_ZPTR:   zptr   <= avs_writedata[15:0];
            `CISE_OFS_CTRL:
            begin
               op       <= cise_op_type'(avs_writedata[`CISE_CTRL_OP_MSB:`CISE_CTRL_OP_LSB]);
               bitsel   <= avs_writedata[`CISE_CTRL_BIT_MSB:`CISE_CTRL_BIT_LSB];
               two_word <= avs_writedata[`CISE_CTRL_TWO_WORD];
            end
            default:          opa    <= opa;
         endcase
      end
   end

   // Cycle counter: a start with an operation runs it on the following edge
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         busy     <= 1'b0;
         cyc_left <= 2'd0;
         cyc_last <= 2'd0;
      end
      else if (start_take)
      begin
         busy     <= 1'b1;
         cyc_left <= 2'd0;
      end
      else if (busy & (cyc_left == 2'd0))
      begin
         cyc_left <= next_cycles - 2'd1;
         cyc_last <= next_cycles;
         busy     <= (next_cycles != `CISE_CYC_ONE);
      end
      else if (busy)
      begin
         cyc_left <= cyc_left - 2'd1;
         busy     <= (cyc_left != 2'd1);
      end
   end

   // Architectural commit on the last cycle, else software writes while idle
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         pc      <= `CISE_RST_WORD;
         status_flags_register    <= `CISE_RST_BYTE;
         ioreg   <= `CISE_RST_BYTE;
         result  <= `CISE_RST_BYTE;
         retaddr <= `CISE_RST_WORD;
      end
      else if (commit)
      begin
         pc      <= next_pc;
         status_flags_register    <= next_status_flags_register;
         ioreg   <= next_io;
         result  <= next_result;
         retaddr <= next_ret;
      end
      else if (wr_take & ~busy)
      begin
         case (avs_address)
            `CISE_OFS_PC:    pc    <= avs_writedata[15:0];
            `CISE_OFS_STATUS_FLAGS_REGISTER:  status_flags_register  <= avs_writedata[7:0];
            `CISE_OFS_IOREG: ioreg <= avs_writedata[7:0];
            default:         pc    <= pc;
         endcase
      end
   end

   // Completion pulse in the cycle after commit
   always_ff @(posedge sys_clk)
   begin
      if (srst)
         exec_done <= 1'b0;
      else
         exec_done <= commit;
   end

endmodule : cise_exec

// >>> cise_exec_asserts.sv
// Checker for the execution block: bus handshake, reset state and operation cycle counts.
// Assumes a bind to cise_exec and a master that holds each request until it is answered.
module cise_exec_asserts
(
   // Clock and reset
   input wire logic        sys_clk,
   input wire logic        srst,
   // Bus and completion
   input wire logic [7:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        exec_done
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);
   // Accepted start write and its op code
   wire logic       st = avs_write && !avs_waitrequest && avs_address == 8'h00 && avs_writedata[16];
   wire logic [5:0] op = avs_writedata[5:0];

   chk_reset_idle: assert property (disable iff (1'b0)
      srst |=> avs_waitrequest && !exec_done && avs_readdata == 32'h0) else $error("bad reset state");
   chk_wait_single: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
      else $error("waitrequest low too long");
   chk_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("request not answered");
   chk_done_pulse: assert property (exec_done |=> !exec_done) else $error("done not a pulse");
   chk_one_cycle: assert property (
      st && op inside {[6'h00:6'h02], [6'h08:6'h0a], [6'h21:6'h28]} |-> ##2 exec_done)
      else $error("single cycle op late");
   chk_two_cycle: assert property (
      st && op inside {6'h03, 6'h04, 6'h1f, 6'h20} |=> !exec_done ##1 !exec_done ##1 exec_done)
      else $error("two cycle op wrong");
   chk_call_three: assert property (
      st && op inside {6'h05, 6'h06} |=> !exec_done [*3] ##1 exec_done) else $error("call wrong");
   chk_skip_cycles: assert property (
      st && op inside {6'h07, [6'h0b:6'h0e]} |-> ##[2:4] exec_done) else $error("skip too long");
   chk_branch_cycles: assert property (
      st && op inside {[6'h0f:6'h1e]} |-> ##[2:3] exec_done) else $error("branch too long");
   chk_done_cause: assert property (exec_done |-> $past(st, 2) || $past(st, 3) || $past(st, 4))
      else $error("done without start");
endmodule : cise_exec_asserts

bind cise_exec cise_exec_asserts chk (.sys_clk, .srst, .avs_address, .avs_read, .avs_write,
   .avs_writedata, .avs_readdata, .avs_waitrequest, .exec_done);

// >>> cise_exec_bench.sv
// Self-checking bench: reset reads, a table of operations, then busy and I/O bit cases.
// Assumes the slave holds waitrequest high until it answers each request.
module cise_exec_bench;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {logic [5:0] op; logic [7:0] a, b, sr; logic [3:0] x;
      logic [7:0] res, sro; logic [2:0] pc;} cise_row_type;
   // Bench signals
   logic         sys_clk = 1'b0;
   logic         srst = 1'b1;
   logic [7:0]   avs_address = 8'h00;
   logic         avs_read = 1'b0;
   logic         avs_write = 1'b0;
   logic [31:0]  avs_writedata = 32'h0;
   logic [31:0]  avs_readdata;
   logic         avs_waitrequest;
   logic         exec_done;
   logic [31:0]  rd;
   int           n_fail = 0;
   int           num_checks = 0;
   cise_row_type rows[$];
   logic [15:0]  pcs [5] = '{16'h0011, 16'h0012, 16'h0013, 16'h000e, 16'h0200};

   // Clock at 50 ns
   always #25 sys_clk = ~sys_clk;

   cise_exec dut (.sys_clk, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_readdata, .avs_waitrequest, .exec_done);

   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : finish_test

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic expire(input int i);
      if (i == 8)
      begin
         n_fail++;
         finish_test();
      end
   endtask : expire

   // One transfer, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
      int i;
      avs_address <= ad;
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= wd;
      for (i = 0; i < 8; i++)
      begin
         @(posedge sys_clk);
         if (avs_waitrequest === 1'b0)
            break;
      end
      expire(i);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge sys_clk);
   endtask : bus

   task automatic done();
      int i;
      for (i = 0; i < 8; i++)
      begin
         @(posedge sys_clk);
         if (exec_done === 1'b1)
            break;
      end
      expire(i);
   endtask : done

   // Load operands with pc 0x0010, offset -3, pointer 0x0200, I/O 0x5a, then start
   task automatic run(input cise_row_type r);
      bus(1'b1, 8'h10, 32'h0010);
      bus(1'b1, 8'h04, {24'h0, r.a});
      bus(1'b1, 8'h08, {24'h0, r.b});
      bus(1'b1, 8'h0c, 32'h0ffd);
      bus(1'b1, 8'h14, 32'h0200);
      bus(1'b1, 8'h18, {24'h0, r.sr});
      bus(1'b1, 8'h1c, 32'h005a);
      bus(1'b1, 8'h00, {15'h0, 1'b1, 3'h0, r.x[3], 1'b0, r.x[2:0], 2'h0, r.op});
   endtask : run

   task automatic add(input logic [5:0] op, input logic [7:0] a, b, sr, input logic [3:0] x,
                      input logic [7:0] res, sro, input logic [2:0] pc);
      rows.push_back({op, a, b, sr, x, res, sro, pc});
   endtask : add

   // Main sequence
   initial
   begin
      add(6'h00, 8'h81, 8'h0c, 8'h08, 4'h0, 8'h8d, 8'h04, 3'd0);
      add(6'h01, 8'h0f, 8'h0f, 8'h00, 4'h0, 8'h00, 8'h02, 3'd0);
      add(6'h02, 8'h80, 8'h00, 8'h0a, 4'h0, 8'h80, 8'h04, 3'd0);
      add(6'h03, 8'h00, 8'h00, 8'hff, 4'h0, 8'h00, 8'hff, 3'd3);
      add(6'h04, 8'h00, 8'h00, 8'h00, 4'h0, 8'h00, 8'h00, 3'd4);
      add(6'h05, 8'h00, 8'h00, 8'h00, 4'h0, 8'h00, 8'h00, 3'd3);
      add(6'h06, 8'h00, 8'h00, 8'h00, 4'h0, 8'h00, 8'h00, 3'd4);
      add(6'h07, 8'h33, 8'h33, 8'h00, 4'h8, 8'h33, 8'h00, 3'd2);
      add(6'h08, 8'h10, 8'h20, 8'h00, 4'h0, 8'h10, 8'h05, 3'd0);
      add(6'h09, 8'h20, 8'h10, 8'h03, 4'h0, 8'h20, 8'h20, 3'd0);
      add(6'h0a, 8'h80, 8'h01, 8'h00, 4'h0, 8'h80, 8'h28, 3'd0);
      add(6'h0b, 8'h08, 8'h00, 8'h00, 4'h3, 8'h08, 8'h00, 3'd0);
      add(6'h0c, 8'h08, 8'h00, 8'h00, 4'hb, 8'h08, 8'h00, 3'd2);
      add(6'h0d, 8'h00, 8'h00, 8'h00, 4'h0, 8'h00, 8'h00, 3'd1);
      add(6'h0e, 8'h00, 8'h00, 8'h00, 4'h9, 8'h00, 8'h00, 3'd2);
      add(6'h0f, 8'h00, 8'h00, 8'h80, 4'h7, 8'h00, 8'h80, 3'd3);
      add(6'h10, 8'h00, 8'h00, 8'h80, 4'h7, 8'h00, 8'h80, 3'd0);
      add(6'h11, 8'h00, 8'h00, 8'h0c, 4'h0, 8'h00, 8'h0c, 3'd3);
      add(6'h12, 8'h00, 8'h00, 8'h0c, 4'h0, 8'h00, 8'h0c, 3'd0);
      add(6'h13, 8'h00, 8'h00, 8'h20, 4'h0, 8'h00, 8'h20, 3'd3);
      add(6'h14, 8'h00, 8'h00, 8'h20, 4'h0, 8'h00, 8'h20, 3'd0);
      add(6'h15, 8'h00, 8'h00, 8'h00, 4'h0, 8'h00, 8'h00, 3'd0);
      add(6'h16, 8'h00, 8'h00, 8'h00, 4'h0, 8'h00, 8'h00, 3'd3);
      add(6'h17, 8'h00, 8'h00, 8'h08, 4'h0, 8'h00, 8'h08, 3'd3);
      add(6'h18, 8'h00, 8'h00, 8'h08, 4'h0, 8'h00, 8'h08, 3'd0);
      add(6'h19, 8'h00, 8'h00, 8'h00, 4'h0, 8'h00, 8'h00, 3'd0);
      add(6'h1a, 8'h00, 8'h00, 8'h00, 4'h0, 8'h00, 8'h00, 3'd3);
      add(6'h1b, 8'h00, 8'h00, 8'h00, 4'h0, 8'h00, 8'h00, 3'd3);
      add(6'h1c, 8'h00, 8'h00, 8'h00, 4'h0, 8'h00, 8'h00, 3'd0);
      add(6'h1d, 8'h00, 8'h00, 8'h01, 4'h0, 8'h00, 8'h01, 3'd3);
      add(6'h1e, 8'h00, 8'h00, 8'h01, 4'h0, 8'h00, 8'h01, 3'd0);
      add(6'h21, 8'h81, 8'h00, 8'h00, 4'h0, 8'h02, 8'h09, 3'd0);
      add(6'h22, 8'h01, 8'h00, 8'h00, 4'h0, 8'h00, 8'h0b, 3'd0);
      add(6'h23, 8'h00, 8'h00, 8'h00, 4'h0, 8'hff, 8'h05, 3'd0);
      add(6'h24, 8'h01, 8'h00, 8'h00, 4'h0, 8'hff, 8'h25, 3'd0);
      add(6'h25, 8'h7f, 8'h00, 8'h00, 4'h0, 8'h80, 8'h0c, 3'd0);
      add(6'h26, 8'h80, 8'h00, 8'h00, 4'h0, 8'h7f, 8'h08, 3'd0);
      add(6'h27, 8'h55, 8'h00, 8'h0c, 4'h0, 8'h00, 8'h02, 3'd0);
      add(6'h28, 8'h12, 8'h00, 8'h5a, 4'h0, 8'hff, 8'h5a, 3'd0);
      add(6'h3f, 8'h42, 8'h00, 8'h5a, 4'h0, 8'h42, 8'h5a, 3'd0); // Unknown code: pc+1, result takes opa, flags kept
      repeat (20) @(posedge sys_clk);
      srst <= 1'b0;
      @(posedge sys_clk);
      // Registers read zero after reset, and so does an unmapped place
      for (int a = 0; a <= 'h28; a += 4)
      begin
         bus(1'b0, 8'(a), 32'h0);
         check(rd, 32'h0);
      end
      bus(1'b0, 8'h40, 32'h0);
      check(rd, 32'h0);
      foreach (rows[i])
      begin
         run(rows[i]);
         done();
         bus(1'b0, 8'h20, 32'h0);
         check(rd, {24'h0, rows[i].res});
         bus(1'b0, 8'h10, 32'h0);
         check(rd, {16'h0, pcs[rows[i].pc]});
         bus(1'b0, 8'h18, 32'h0);
         check(rd, {24'h0, rows[i].sro});
      end
      // Call still busy when read back, then return address
      run(rows[5]);
      bus(1'b0, 8'h00, 32'h0);
      check(rd[16], 1'b1);
      bus(1'b0, 8'h24, 32'h0);
      check(rd, 32'h0011);
      bus(1'b0, 8'h28, 32'h0);
      check(rd, 32'h000c);
      // Set then clear one I/O bit, flags kept
      run({6'h1f, 8'h00, 8'h00, 8'hff, 4'h0, 8'h00, 8'hff, 3'd0});
      done();
      bus(1'b0, 8'h1c, 32'h0);
      check(rd, 32'h005b);
      bus(1'b0, 8'h28, 32'h0);
      check(rd, 32'h0008);
      run({6'h20, 8'h00, 8'h00, 8'hff, 4'h1, 8'h00, 8'hff, 3'd0});
      done();
      bus(1'b0, 8'h1c, 32'h0);
      check(rd, 32'h0058);
      bus(1'b0, 8'h18, 32'h0);
      check(rd, 32'h00ff);
      finish_test();
   end
endmodule : cise_exec_bench
